// File: core/pdcg_defs.vh
`ifndef PDCG_DEFS_VH
`define PDCG_DEFS_VH

// ****************************************
// Register addresses (page and offset)
// ****************************************
`define PDCG_ADDR_DIV_ENABLE 16'h0A03
`define PDCG_ADDR_INT_FORCE 16'h0A04
`define PDCG_ADDR_DIV_POWER 16'h0A05
`define PDCG_ADDR_INIT_A 16'h0B24
`define PDCG_ADDR_INIT_B 16'h0B25
`define PDCG_ADDR_FRAC_GATE 16'h0B44
`define PDCG_ADDR_LOCK_GATE 16'h0B45
`define PDCG_ADDR_SIG_GATE 16'h0B46
`define PDCG_ADDR_FOFS_GATE 16'h0B47
`define PDCG_ADDR_FOFS_DIV_GATE 16'h0B48
`define PDCG_ADDR_DIV_GATE 16'h0B4A
`define PDCG_ADDR_INIT_C 16'h0B4E
`define PDCG_ADDR_CAL_LOW 16'h0B57
`define PDCG_ADDR_CAL_HIGH 16'h0B58
`define PDCG_ADDR_RESET_CTRL 16'h001C

// ****************************************
// Field positions and widths
// ****************************************
`define PDCG_NUM_DIV 5
`define PDCG_NUM_PLL 4
`define PDCG_NUM_IN 4
`define PDCG_FB_FRAC_LSB 4
`define PDCG_FB_GATE_BIT 5
`define PDCG_CAL_BLOCK_BIT 6
`define PDCG_SOFT_RST_BIT 0

// ****************************************
// Reset values
// ****************************************
`define PDCG_RST_BYTE 8'h00
`define PDCG_RST_CAL 12'h000

`endif

// File: core/pdcg_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "pdcg_defs.vh"

module pdcg_regs #(
    parameter NDIV = `PDCG_NUM_DIV
) (
    // Clock and reset
    input wire i_clock,
    input wire i_rst,
    // Register port from the serial configuration interface
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output reg o_rd_valid,
    // Divider controls
    output reg [NDIV-1:0] o_div_run,
    output reg [NDIV-1:0] o_div_power,
    output reg [NDIV-1:0] o_div_clk_gate,
    output reg [NDIV-1:0] o_integer_force_select,
    // Fractional and monitor gates
    output reg [3:0] o_input_div_frac_gate,
    output reg [3:0] o_feedback_frac_gate,
    output reg [3:0] o_lock_loss_gate,
    output reg [3:0] o_signal_loss_gate,
    output reg [4:0] o_freq_offset_gate,
    output reg [4:0] o_freq_offset_divider_gate,
    output reg o_feedback_divider_gate,
    output reg o_feedback_cal_block,
    // Initialization storage
    output reg [7:0] o_init_a,
    output reg [7:0] o_init_b,
    output reg [7:0] o_init_c,
    output reg [11:0] o_vco_cal_code,
    // Soft reset pulse
    output reg o_soft_reset
);

    // ****************************************
    // Stored registers
    // ****************************************
    reg [7:0] enable_q;
    reg [7:0] int_force_q;
    reg [7:0] power_q;
    reg [7:0] frac_gate_q;
    reg [7:0] lock_gate_q;
    reg [7:0] sig_gate_q;
    reg [7:0] fofs_gate_q;
    reg [7:0] fofs_div_gate_q;
    reg [7:0] div_gate_q;
    reg [7:0] init_a_q;
    reg [7:0] init_b_q;
    reg [7:0] init_c_q;
    reg [7:0] cal_low_q;
    reg [7:0] cal_high_q;
    // Integer mode as applied; only a full soft reset loads it
    reg [NDIV-1:0] int_applied_q;
    reg soft_rst_q;
    reg [7:0] rdata_d;

    // ****************************************
    // Address decode
    // ****************************************
    wire sel_enable;
    wire sel_int_force;
    wire sel_power;
    wire sel_init_a;
    wire sel_init_b;
    wire sel_frac_gate;
    wire sel_lock_gate;
    wire sel_sig_gate;
    wire sel_fofs_gate;
    wire sel_fofs_div_gate;
    wire sel_div_gate;
    wire sel_init_c;
    wire sel_cal_low;
    wire sel_cal_high;
    wire sel_reset_ctrl;
    wire soft_rst_req;

    assign sel_enable = (i_addr == `PDCG_ADDR_DIV_ENABLE);
    assign sel_int_force = (i_addr == `PDCG_ADDR_INT_FORCE);
    assign sel_power = (i_addr == `PDCG_ADDR_DIV_POWER);
    assign sel_init_a = (i_addr == `PDCG_ADDR_INIT_A);
    assign sel_init_b = (i_addr == `PDCG_ADDR_INIT_B);
    assign sel_frac_gate = (i_addr == `PDCG_ADDR_FRAC_GATE);
    assign sel_lock_gate = (i_addr == `PDCG_ADDR_LOCK_GATE);
    assign sel_sig_gate = (i_addr == `PDCG_ADDR_SIG_GATE);
    assign sel_fofs_gate = (i_addr == `PDCG_ADDR_FOFS_GATE);
    assign sel_fofs_div_gate = (i_addr == `PDCG_ADDR_FOFS_DIV_GATE);
    assign sel_div_gate = (i_addr == `PDCG_ADDR_DIV_GATE);
    assign sel_init_c = (i_addr == `PDCG_ADDR_INIT_C);
    assign sel_cal_low = (i_addr == `PDCG_ADDR_CAL_LOW);
    assign sel_cal_high = (i_addr == `PDCG_ADDR_CAL_HIGH);
    assign sel_reset_ctrl = (i_addr == `PDCG_ADDR_RESET_CTRL);
    // Reset control is not stored; bit 0 only fires the pulse
    assign soft_rst_req = i_wr_en && sel_reset_ctrl && i_wdata[`PDCG_SOFT_RST_BIT];

    // ****************************************
    // Register writes
    // ****************************************
    // One block per register; a write touches only its own bits
    always @(posedge i_clock) begin
        if (i_rst) begin
            enable_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_enable) begin
            enable_q <= {3'h0, i_wdata[4:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            int_force_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_int_force) begin
            int_force_q <= {3'h0, i_wdata[4:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            power_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_power) begin
            power_q <= {3'h0, i_wdata[4:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            frac_gate_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_frac_gate) begin
            frac_gate_q <= i_wdata;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            lock_gate_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_lock_gate) begin
            lock_gate_q <= {4'h0, i_wdata[3:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            sig_gate_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_sig_gate) begin
            sig_gate_q <= {4'h0, i_wdata[3:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            fofs_gate_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_fofs_gate) begin
            fofs_gate_q <= {3'h0, i_wdata[4:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            fofs_div_gate_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_fofs_div_gate) begin
            fofs_div_gate_q <= {3'h0, i_wdata[4:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            div_gate_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_div_gate) begin
            div_gate_q <= {1'h0, i_wdata[6:0]};
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            init_a_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_init_a) begin
            init_a_q <= i_wdata;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            init_b_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_init_b) begin
            init_b_q <= i_wdata;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            init_c_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_init_c) begin
            init_c_q <= i_wdata;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            cal_low_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_cal_low) begin
            cal_low_q <= i_wdata;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            cal_high_q <= `PDCG_RST_BYTE;
        end else if (i_wr_en && sel_cal_high) begin
            cal_high_q <= {4'h0, i_wdata[3:0]};
        end
    end

    // ****************************************
    // Soft reset and applied divider mode
    // ****************************************
    always @(posedge i_clock) begin
        if (i_rst) begin
            soft_rst_q <= 1'b0;
            int_applied_q <= {NDIV{1'b0}};
        end else begin
            soft_rst_q <= soft_rst_req;
            if (soft_rst_req) begin
                int_applied_q <= int_force_q[NDIV-1:0];
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always @* begin
        case (i_addr)
            `PDCG_ADDR_DIV_ENABLE: rdata_d = enable_q;
            `PDCG_ADDR_INT_FORCE: rdata_d = int_force_q;
            `PDCG_ADDR_DIV_POWER: rdata_d = power_q;
            `PDCG_ADDR_FRAC_GATE: rdata_d = frac_gate_q;
            `PDCG_ADDR_LOCK_GATE: rdata_d = lock_gate_q;
            `PDCG_ADDR_SIG_GATE: rdata_d = sig_gate_q;
            `PDCG_ADDR_FOFS_GATE: rdata_d = fofs_gate_q;
            `PDCG_ADDR_FOFS_DIV_GATE: rdata_d = fofs_div_gate_q;
            `PDCG_ADDR_DIV_GATE: rdata_d = div_gate_q;
            `PDCG_ADDR_INIT_A: rdata_d = init_a_q;
            `PDCG_ADDR_INIT_B: rdata_d = init_b_q;
            `PDCG_ADDR_INIT_C: rdata_d = init_c_q;
            `PDCG_ADDR_CAL_LOW: rdata_d = cal_low_q;
            `PDCG_ADDR_CAL_HIGH: rdata_d = cal_high_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rdata_d;
            end
        end
    end

    // ****************************************
    // Per-divider control outputs
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NDIV; g = g + 1) begin : g_div
            always @(posedge i_clock) begin
                if (i_rst) begin
                    o_div_run[g] <= 1'b0;
                    o_div_power[g] <= 1'b0;
                    o_div_clk_gate[g] <= 1'b0;
                    o_integer_force_select[g] <= 1'b0;
                end else begin
                    o_div_run[g] <= enable_q[g] && power_q[g] && !div_gate_q[g];
                    o_div_power[g] <= power_q[g];
                    o_div_clk_gate[g] <= div_gate_q[g];
                    o_integer_force_select[g] <= int_applied_q[g];
                end
            end
        end
    endgenerate

    // ****************************************
    // Per-channel gate outputs
    // ****************************************
    genvar c;
    generate
        for (c = 0; c < `PDCG_NUM_PLL; c = c + 1) begin : g_chan
            always @(posedge i_clock) begin
                if (i_rst) begin
                    o_input_div_frac_gate[c] <= 1'b0;
                    o_feedback_frac_gate[c] <= 1'b0;
                    o_lock_loss_gate[c] <= 1'b0;
                    o_signal_loss_gate[c] <= 1'b0;
                end else begin
                    o_input_div_frac_gate[c] <= frac_gate_q[c];
                    o_feedback_frac_gate[c] <= frac_gate_q[`PDCG_FB_FRAC_LSB+c];
                    o_lock_loss_gate[c] <= lock_gate_q[c];
                    o_signal_loss_gate[c] <= sig_gate_q[c];
                end
            end
        end
    endgenerate

    // ****************************************
    // Shared control outputs
    // ****************************************
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_freq_offset_gate <= 5'h00;
            o_freq_offset_divider_gate <= 5'h00;
            o_feedback_divider_gate <= 1'b0;
            o_feedback_cal_block <= 1'b0;
            o_init_a <= 8'h00;
            o_init_b <= 8'h00;
            o_init_c <= 8'h00;
            o_vco_cal_code <= `PDCG_RST_CAL;
            o_soft_reset <= 1'b0;
        end else begin
            o_freq_offset_gate <= fofs_gate_q[4:0];
            o_freq_offset_divider_gate <= fofs_div_gate_q[4:0];
            o_feedback_divider_gate <= div_gate_q[`PDCG_FB_GATE_BIT];
            o_feedback_cal_block <= div_gate_q[`PDCG_CAL_BLOCK_BIT];
            o_init_a <= init_a_q;
            o_init_b <= init_b_q;
            o_init_c <= init_c_q;
            o_vco_cal_code <= {cal_high_q[3:0], cal_low_q};
            o_soft_reset <= soft_rst_q;
        end
    end

endmodule

`default_nettype wire

// File: dv/pdcg_host.sv
`timescale 1ns/1ps
`default_nettype none
module pdcg_host (
    // Clock
    input wire logic i_clock,
    // Register port
    output logic o_wr_en = 1'b0,
    output logic o_rd_en = 1'b0,
    output logic [15:0] o_addr = 16'h0000,
    output logic [7:0] o_wdata = 8'h00,
    input wire logic [7:0] i_rdata,
    input wire logic i_rd_valid
);
    // Released lines show the inverse value
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clock);
        o_wr_en <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [8:0] v);
        @(posedge i_clock);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_clock);
        o_rd_en <= 1'b0;
        o_addr <= ~a;
        @(posedge i_clock);
        v = {i_rd_valid, i_rdata};
    endtask
endmodule
`default_nettype wire

// File: dv/pdcg_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pdcg_regs_chk #(
    parameter NDIV = 5
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic o_rd_valid,
    // Controls
    input wire logic [NDIV-1:0] o_div_run,
    input wire logic [NDIV-1:0] o_integer_force_select,
    input wire logic [3:0] o_feedback_frac_gate,
    input wire logic [11:0] o_vco_cal_code,
    input wire logic o_soft_reset
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_rv; i_rd_en |=> o_rd_valid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_rv0; !i_rd_en |=> !o_rd_valid; endproperty
    a_rv0: assert property (p_rv0) else $error("stray read valid");
    property p_pw;
        i_wr_en && i_addr == 16'h0A05 |-> ##2 (o_div_run & ~$past(i_wdata[NDIV-1:0], 2)) == '0;
    endproperty
    a_pw: assert property (p_pw) else $error("divider runs unpowered");
    property p_gt;
        i_wr_en && i_addr == 16'h0B4A |-> ##2 (o_div_run & $past(i_wdata[NDIV-1:0], 2)) == '0;
    endproperty
    a_gt: assert property (p_gt) else $error("gated divider runs");
    property p_fb;
        i_wr_en && i_addr == 16'h0B44 |-> ##2 o_feedback_frac_gate == $past(i_wdata[7:4], 2);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback gate wrong");
    property p_vc;
        i_wr_en && i_addr == 16'h0B58 |-> ##2 o_vco_cal_code[11:8] == $past(i_wdata[3:0], 2);
    endproperty
    a_vc: assert property (p_vc) else $error("cal code high wrong");
    property p_sr; i_wr_en && i_addr == 16'h001C && i_wdata[0] |-> ##2 o_soft_reset; endproperty
    a_sr: assert property (p_sr) else $error("no soft reset");
    property p_if; $changed(o_integer_force_select) && !$past(i_rst) |-> o_soft_reset; endproperty
    a_if: assert property (p_if) else $error("mode changed early");
endmodule
bind pdcg_regs pdcg_regs_chk #(.NDIV(NDIV)) i_pdcg_regs_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rd_valid(o_rd_valid), .o_div_run(o_div_run), .o_soft_reset(o_soft_reset),
    .o_integer_force_select(o_integer_force_select), .o_vco_cal_code(o_vco_cal_code),
    .o_feedback_frac_gate(o_feedback_frac_gate));
`default_nettype wire

// File: dv/pdcg_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pdcg_regs_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    wire i_wr_en, i_rd_en, o_rd_valid, o_feedback_divider_gate, o_feedback_cal_block, o_soft_reset;
    wire [15:0] i_addr;
    wire [7:0] i_wdata, o_rdata, o_init_a, o_init_b, o_init_c;
    wire [4:0] o_div_run, o_div_power, o_div_clk_gate, o_integer_force_select;
    wire [4:0] o_freq_offset_gate, o_freq_offset_divider_gate;
    wire [3:0] o_input_div_frac_gate, o_feedback_frac_gate, o_lock_loss_gate, o_signal_loss_gate;
    wire [11:0] o_vco_cal_code;
    logic [15:0] ad[14] = '{16'h0A03, 16'h0A04, 16'h0A05, 16'h0B24, 16'h0B25, 16'h0B44,
        16'h0B45, 16'h0B46, 16'h0B47, 16'h0B48, 16'h0B4A, 16'h0B4E, 16'h0B57, 16'h0B58};
    logic [7:0] mk[14] = '{8'h1F, 8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h1F,
        8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'h0F};
    logic [15:0] sa[4] = '{16'h0B4A, 16'h0B4A, 16'h0A05, 16'h0A03};
    logic [7:0] sd[4] = '{8'h00, 8'h05, 8'h1D, 8'h08};
    logic [4:0] sr[4] = '{5'h1F, 5'h1A, 5'h18, 5'h08};
    logic [8:0] v;
    int n_fail = 0;
    int n_tests = 0;
    pdcg_regs i_pdcg_regs (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid),
        .o_div_run(o_div_run),
        .o_div_power(o_div_power),
        .o_div_clk_gate(o_div_clk_gate),
        .o_integer_force_select(o_integer_force_select),
        .o_input_div_frac_gate(o_input_div_frac_gate),
        .o_feedback_frac_gate(o_feedback_frac_gate),
        .o_lock_loss_gate(o_lock_loss_gate),
        .o_signal_loss_gate(o_signal_loss_gate),
        .o_freq_offset_gate(o_freq_offset_gate),
        .o_freq_offset_divider_gate(o_freq_offset_divider_gate),
        .o_feedback_divider_gate(o_feedback_divider_gate),
        .o_feedback_cal_block(o_feedback_cal_block),
        .o_init_a(o_init_a),
        .o_init_b(o_init_b),
        .o_init_c(o_init_c),
        .o_vco_cal_code(o_vco_cal_code),
        .o_soft_reset(o_soft_reset)
    );
    pdcg_host i_pdcg_host (.i_clock(i_clock), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wdata(i_wdata), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial forever #5 i_clock = ~i_clock;
    initial begin
        #200000;
        n_fail++;
        test_done;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        foreach (ad[k]) begin
            i_pdcg_host.rd(ad[k], v);
            chk(v, 9'h100);
            i_pdcg_host.wr(ad[k], 8'hFF);
            i_pdcg_host.rd(ad[k], v);
            chk(v, {1'b1, mk[k]});
        end
        chk({o_input_div_frac_gate, o_feedback_frac_gate}, 8'hFF);
        chk({o_lock_loss_gate, o_signal_loss_gate}, 8'hFF);
        chk({o_feedback_cal_block, o_feedback_divider_gate, o_div_run}, 7'h60);
        chk({o_vco_cal_code, o_integer_force_select}, 17'h1FFE0);
        chk({o_init_a, o_init_b, o_init_c}, 24'hFFFFFF);
        chk({o_div_power, o_div_clk_gate, o_freq_offset_gate, o_freq_offset_divider_gate}, 20'hFFFFF);
        i_pdcg_host.wr(16'h0B49, 8'hFF);
        i_pdcg_host.rd(16'h0B49, v);
        chk(v, 9'h100);
        foreach (sa[k]) begin
            i_pdcg_host.wr(sa[k], sd[k]);
            repeat (2) @(posedge i_clock);
            chk(o_div_run, sr[k]);
        end
        chk({o_div_power, o_div_clk_gate}, 10'h3A5);
        i_pdcg_host.wr(16'h0A04, 8'h15);
        repeat (3) @(posedge i_clock);
        chk(o_integer_force_select, 5'h00);
        i_pdcg_host.wr(16'h001C, 8'h01);
        repeat (2) @(posedge i_clock);
        chk({o_soft_reset, o_integer_force_select}, 6'h35);
        i_pdcg_host.rd(16'h001C, v);
        chk(v, 9'h100);
        chk(o_soft_reset, 1'b0);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        i_pdcg_host.rd(16'h0B57, v);
        chk(v, 9'h100);
        chk({o_soft_reset, o_integer_force_select, o_div_run}, 11'h000);
        test_done;
    end
endmodule
`default_nettype wire
